// *** hw/aior_pkg.sv ***
// ----------------------------------------------------------------------------
// Shared constants and types for the audio router
// ----------------------------------------------------------------------------
package aior_pkg;
    localparam int unsigned SAMPLE_W = 24;

    typedef logic [SAMPLE_W-1:0]         aior_sample_t;
    typedef logic [7:0][SAMPLE_W-1:0]    aior_bus8_t;
    typedef logic [1:0][SAMPLE_W-1:0]    aior_bus2_t;
    typedef logic [1:0]                  aior_src_t;

    // Source codes for processor inputs and main outputs
    localparam aior_src_t SRC_BLOCK = 2'h0;
    localparam aior_src_t SRC_DSPA  = 2'h1;
    localparam aior_src_t SRC_DSPB  = 2'h2;

    // Slot indices that own a selectable native pair
    localparam int unsigned SLOT_PAIR12_LO = 0;
    localparam int unsigned SLOT_PAIR12_HI = 1;
    localparam int unsigned SLOT_PAIR78_LO = 6;
    localparam int unsigned SLOT_PAIR78_HI = 7;

    // Card address space, bytes
    localparam int unsigned CARD_ADDR_W = 23;
    localparam logic [CARD_ADDR_W-1:0] CARD_BYTES = 23'h400000;

    // Activity stretch for the busy indicator
    localparam int unsigned CLK_HZ      = 200_000_000;
    localparam int unsigned ACT_HOLD_MS = 50;
    localparam int unsigned ACT_CNT_W   = 24;
    localparam logic [ACT_CNT_W-1:0] ACT_HOLD_CYC =
        ACT_CNT_W'(ACT_HOLD_MS * (CLK_HZ / 1000));

    // Routing configuration, as held and applied
    typedef struct packed {
        logic             pair12_con;
        logic             pair78_ana;
        logic [7:0]       slot_opt;
        logic [7:0][2:0]  slot_ch;
        aior_src_t        dspa_src;
        aior_src_t        dspb_src;
        logic [7:0][1:0]  main_src;
        logic             opt_from_main;
    } aior_cfg_s;

    // Reset routing: every slot on its own professional input
    localparam aior_cfg_s CFG_RST = '{
        pair12_con:    1'b0,
        pair78_ana:    1'b0,
        slot_opt:      8'h00,
        slot_ch:       24'h000000,
        dspa_src:      SRC_BLOCK,
        dspb_src:      SRC_BLOCK,
        main_src:      16'h0000,
        opt_from_main: 1'b0
    };
endpackage

// *** hw/aior_srcsel.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Three-way source selector for one channel
// ----------------------------------------------------------------------------
module aior_srcsel (
    // Select
    input  wire aior_pkg::aior_src_t    sel,
    // Candidate sources
    input  wire aior_pkg::aior_sample_t blk,
    input  wire aior_pkg::aior_sample_t dspa,
    input  wire aior_pkg::aior_sample_t dspb,
    // Result
    output var   aior_pkg::aior_sample_t y
);
    import aior_pkg::*;

    // Unused code gives silence rather than a stale channel
    always_comb begin
        case (sel)
            SRC_BLOCK: y = blk;
            SRC_DSPA:  y = dspa;
            SRC_DSPB:  y = dspb;
            default:   y = '0;
        endcase
    end
endmodule

// *** hw/aior_router.sv ***
`timescale 1ns/1ps
module aior_router #(
    parameter logic [aior_pkg::ACT_CNT_W-1:0] ACT_CYCLES = aior_pkg::ACT_HOLD_CYC
) (
    // Clock and reset
    input  wire  logic                    clk,
    input  wire  logic                    rst,
    // Audio sources
    input  wire  aior_pkg::aior_bus8_t    pro_in,
    input  wire  aior_pkg::aior_bus8_t    opt_in,
    input  wire  aior_pkg::aior_bus2_t    con_in,
    input  wire  aior_pkg::aior_bus2_t    ana_in,
    input  wire  aior_pkg::aior_bus8_t    dspa_out,
    input  wire  aior_pkg::aior_bus8_t    dspb_out,
    input  wire  logic                    frame_tick,
    // Routing settings
    input  wire  aior_pkg::aior_cfg_s     cfg_in,
    // Card and activity
    input  wire  logic                    card_present_pin,
    input  wire  logic                    midi_rx_pin,
    input  wire  logic                    serial_rx_pin,
    input  wire  logic                    card_wr,
    input  wire  logic [aior_pkg::CARD_ADDR_W-1:0] card_addr,
    // Routed audio
    output var   aior_pkg::aior_bus8_t    slot_out,
    output var   aior_pkg::aior_bus8_t    dspa_in,
    output var   aior_pkg::aior_bus8_t    dspb_in,
    output var   aior_pkg::aior_bus8_t    main_out,
    output var   aior_pkg::aior_bus2_t    con_out,
    output var   aior_pkg::aior_bus2_t    ana_out,
    output var   aior_pkg::aior_bus8_t    opt_out,
    // Status
    output logic                          busy_led,
    output logic                          card_wr_ok,
    output logic                          card_range_err
);
    import aior_pkg::*;

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    typedef struct packed {
        aior_cfg_s              cfg;
        aior_bus8_t             slot;
        aior_bus8_t             dspa;
        aior_bus8_t             dspb;
        aior_bus8_t             main;
        aior_bus2_t             con;
        aior_bus2_t             ana;
        aior_bus8_t             opt;
        logic [1:0]             card_q;
        logic [2:0]             midi_q;
        logic [2:0]             ser_q;
        logic [ACT_CNT_W-1:0]   act_cnt;
        logic                   busy;
        logic                   wr_ok;
        logic                   range_err;
    } aior_st_s;

    aior_st_s   st_r;
    aior_st_s   st_nxt;
    aior_bus8_t slot_c;
    aior_bus8_t dspa_c;
    aior_bus8_t dspb_c;
    aior_bus8_t main_c;

    // ------------------------------------------------------------------------
    // Input block
    // ------------------------------------------------------------------------
    // Applied settings only; a half-changed setting never reaches the mux
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (st_r.cfg.slot_opt[i]) begin
                slot_c[i] = opt_in[st_r.cfg.slot_ch[i]];
            end else if ((i == SLOT_PAIR12_LO || i == SLOT_PAIR12_HI)
                         && st_r.cfg.pair12_con) begin
                slot_c[i] = con_in[i[0]];
            end else if ((i == SLOT_PAIR78_LO || i == SLOT_PAIR78_HI)
                         && st_r.cfg.pair78_ana) begin
                slot_c[i] = ana_in[i[0]];
            end else begin
                slot_c[i] = pro_in[i];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Processor and main output selection
    // ------------------------------------------------------------------------
    // One selector per channel, shared form for all three destinations
    for (genvar g = 0; g < 8; g++) begin : g_chan
        aior_srcsel u_dspa (
            .sel  (st_r.cfg.dspa_src),
            .blk  (slot_c[g]),
            .dspa (dspa_out[g]),
            .dspb (dspb_out[g]),
            .y    (dspa_c[g])
        );
        aior_srcsel u_dspb (
            .sel  (st_r.cfg.dspb_src),
            .blk  (slot_c[g]),
            .dspa (dspa_out[g]),
            .dspb (dspb_out[g]),
            .y    (dspb_c[g])
        );
        aior_srcsel u_main (
            .sel  (st_r.cfg.main_src[g]),
            .blk  (slot_c[g]),
            .dspa (dspa_out[g]),
            .dspb (dspb_out[g]),
            .y    (main_c[g])
        );
    end

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        // Settings land only on the frame strobe
        if (frame_tick) begin
            st_nxt.cfg = cfg_in;
        end
        st_nxt.slot = slot_c;
        st_nxt.dspa = dspa_c;
        st_nxt.dspb = dspb_c;
        st_nxt.main = main_c;
        // Mirrors tap the same registered stage, so they stay aligned
        st_nxt.con  = main_c[1:0];
        st_nxt.ana  = main_c[7:6];
        st_nxt.opt  = st_r.cfg.opt_from_main ? main_c : opt_in;
        // Card pin passes two flops, line pins three; edge test uses only the later stages
        st_nxt.card_q = {st_r.card_q[0], card_present_pin};
        st_nxt.midi_q = {st_r.midi_q[1:0], midi_rx_pin};
        st_nxt.ser_q  = {st_r.ser_q[1:0], serial_rx_pin};
        // Stretch each line edge so a short burst stays visible
        if ((st_r.midi_q[2] ^ st_r.midi_q[1]) || (st_r.ser_q[2] ^ st_r.ser_q[1])) begin
            st_nxt.act_cnt = ACT_CYCLES;
        end else if (st_r.act_cnt != '0) begin
            st_nxt.act_cnt = st_r.act_cnt - 1'b1;
        end
        // Card present: write activity; absent: data activity
        if (st_r.card_q[1]) begin
            st_nxt.busy = card_wr;
        end else begin
            st_nxt.busy = (st_r.act_cnt != '0);
        end
        // Writes past the card's top byte are refused
        st_nxt.wr_ok     = card_wr && st_r.card_q[1] && (card_addr < CARD_BYTES);
        st_nxt.range_err = card_wr && (card_addr >= CARD_BYTES);
    end

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    // Audio words reset to silence so nothing stale leaves at start-up
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r     <= '0;
            st_r.cfg <= CFG_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from flops
    assign slot_out       = st_r.slot;
    assign dspa_in        = st_r.dspa;
    assign dspb_in        = st_r.dspb;
    assign main_out       = st_r.main;
    assign con_out        = st_r.con;
    assign ana_out        = st_r.ana;
    assign opt_out        = st_r.opt;
    assign busy_led       = st_r.busy;
    assign card_wr_ok     = st_r.wr_ok;
    assign card_range_err = st_r.range_err;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_cfg_frame_hold: assert property (!frame_tick |=> $stable(st_r.cfg))
        else $error("routing changed off frame boundary");
    a_cfg_frame_load: assert property (frame_tick |=> st_r.cfg == $past(cfg_in))
        else $error("routing not loaded at frame boundary");
    a_reset_default: assert property (@(posedge clk) disable iff (1'b0)
        rst |=> st_r.cfg == CFG_RST)
        else $error("reset routing not professional in order");
    a_slot1_consumer: assert property ((!frame_tick && !st_r.cfg.slot_opt[0]
        && st_r.cfg.pair12_con) |=> slot_out[0] == $past(con_in[0]))
        else $error("slot one not consumer input");
    a_slot2_pro: assert property ((!frame_tick && !st_r.cfg.slot_opt[1]
        && !st_r.cfg.pair12_con) |=> slot_out[1] == $past(pro_in[1]))
        else $error("slot two not professional input");
    a_slot8_analog: assert property ((!frame_tick && !st_r.cfg.slot_opt[7]
        && st_r.cfg.pair78_ana) |=> slot_out[7] == $past(ana_in[1]))
        else $error("slot eight not analog input");
    a_slot_optical: assert property ((!frame_tick && st_r.cfg.slot_opt[3])
        |=> slot_out[3] == $past(opt_in[st_r.cfg.slot_ch[3]]))
        else $error("optical slot carries wrong source");
    a_dspa_route: assert property ((!frame_tick && st_r.cfg.dspa_src == SRC_DSPB)
        |=> dspa_in == $past(dspb_out))
        else $error("processor A input not from processor B");
    a_main_route: assert property ((!frame_tick && st_r.cfg.main_src[2] == SRC_DSPA)
        |=> main_out[2] == $past(dspa_out[2]))
        else $error("main output not from processor A");
    a_mirror_taps: assert property (con_out == main_out[1:0]
        && ana_out == main_out[7:6])
        else $error("mirror outputs diverge from main");
    a_opt_bypass: assert property ((!frame_tick && !st_r.cfg.opt_from_main)
        |=> opt_out == $past(opt_in))
        else $error("optical bypass broken");
    a_busy_card: assert property ((st_r.card_q[1] && card_wr) |=> busy_led)
        else $error("busy dark during card write");
    a_busy_idle: assert property ((!st_r.card_q[1] && st_r.act_cnt == '0)
        |=> !busy_led)
        else $error("busy lit with no activity");
    a_card_range: assert property ((card_wr && card_addr >= CARD_BYTES)
        |=> card_range_err && !card_wr_ok)
        else $error("out of range card write accepted");

    c_optical_slot: cover property (frame_tick && cfg_in.slot_opt != 8'h00);
    c_dsp_chain:    cover property (st_r.cfg.dspb_src == SRC_DSPA);
    c_busy_serial:  cover property (!st_r.card_q[1] ##1 busy_led);
endmodule

// *** bench/aior_dsp_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Behavioural processor: one-cycle pipeline with a per-instance scramble
// ----------------------------------------------------------------------------
module aior_dsp_model #(
    parameter logic [23:0] KEY = 24'h5A5A5A
) (
    // Clock and reset
    input  wire  logic                 clk,
    input  wire  logic                 rst,
    // Audio
    input  wire  aior_pkg::aior_bus8_t din,
    output var   aior_pkg::aior_bus8_t dout
);
    import aior_pkg::*;
    // Scrambled per channel so a wrong source or channel never matches by luck
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dout <= '0;
        end else begin
            for (int i = 0; i < 8; i++) begin
                dout[i] <= din[i] ^ KEY ^ SAMPLE_W'(i);
            end
        end
    end
endmodule

// *** bench/tb.sv ***
`timescale 1ns/1ps
module tb;
    import aior_pkg::*;
    // ------------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------------
    localparam int ACT = 16;
    logic                   clk = 1'b0;
    logic                   rst = 1'b1;
    aior_bus8_t             pro_in, opt_in, dspa_out, dspb_out;
    aior_bus8_t             slot_out, dspa_in, dspb_in, main_out, opt_out;
    aior_bus2_t             con_in, ana_in, con_out, ana_out;
    logic                   frame_tick, card_pin, midi_pin, ser_pin, card_wr;
    logic                   busy_led, card_wr_ok, card_range_err, seen;
    logic [CARD_ADDR_W-1:0] card_addr;
    aior_cfg_s              cfg_in, act;
    aior_bus8_t             e_slot, e_a, e_b, e_main, e_opt;
    logic [63:0]            r;
    logic [22:0]            addrs [4] = '{23'h000000, 23'h3FFFFF, 23'h400000, 23'h7FFFFF};
    int                     num_errors = 0;
    int                     n_checks = 0;
    int                     cycles = 0;
    bit                     valid = 0;
    bit                     mix = 0;

    always #2.5 clk = ~clk;

    aior_router #(.ACT_CYCLES(24'(ACT))) u_aior_router (
        .clk(clk), .rst(rst), .pro_in(pro_in), .opt_in(opt_in), .con_in(con_in),
        .ana_in(ana_in), .dspa_out(dspa_out), .dspb_out(dspb_out),
        .frame_tick(frame_tick), .cfg_in(cfg_in), .card_present_pin(card_pin),
        .midi_rx_pin(midi_pin), .serial_rx_pin(ser_pin), .card_wr(card_wr),
        .card_addr(card_addr), .slot_out(slot_out), .dspa_in(dspa_in),
        .dspb_in(dspb_in), .main_out(main_out), .con_out(con_out), .ana_out(ana_out),
        .opt_out(opt_out), .busy_led(busy_led), .card_wr_ok(card_wr_ok),
        .card_range_err(card_range_err));
    aior_dsp_model #(.KEY(24'h3C0F5A)) u_aior_dsp_model_a (
        .clk(clk), .rst(rst), .din(dspa_in), .dout(dspa_out));
    aior_dsp_model #(.KEY(24'hA5F0C3)) u_aior_dsp_model_b (
        .clk(clk), .rst(rst), .din(dspb_in), .dout(dspb_out));

    // ------------------------------------------------------------------------
    // Checking and reference model
    // ------------------------------------------------------------------------
    task automatic chk(input logic [191:0] s, input logic [191:0] e);
        n_checks++;
        if (s !== e) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    function automatic aior_sample_t pick(aior_src_t s, int i, aior_bus8_t blk);
        case (s)
            SRC_BLOCK: return blk[i];
            SRC_DSPA:  return dspa_out[i];
            SRC_DSPB:  return dspb_out[i];
            default: return '0; // Unused code mutes the channel
        endcase
    endfunction

    // Reference routing of the inputs presented this cycle under the held settings
    task automatic predict();
        for (int i = 0; i < 8; i++) begin
            if (act.slot_opt[i]) e_slot[i] = opt_in[act.slot_ch[i]];
            else if (i < 2 && act.pair12_con) e_slot[i] = con_in[i];
            else if (i > 5 && act.pair78_ana) e_slot[i] = ana_in[i-6];
            else e_slot[i] = pro_in[i];
        end
        for (int i = 0; i < 8; i++) begin
            e_a[i] = pick(act.dspa_src, i, e_slot);
            e_b[i] = pick(act.dspb_src, i, e_slot);
            e_main[i] = pick(act.main_src[i], i, e_slot);
            e_opt[i] = act.opt_from_main ? e_main[i] : opt_in[i];
        end
    endtask

    // One cycle: compare last cycle's routing, then drive fresh stimulus
    task automatic cyc();
        @(negedge clk);
        if (valid) begin
            chk(slot_out, e_slot);
            chk(dspa_in, e_a);
            chk(dspb_in, e_b);
            chk(main_out, e_main);
            chk({144'h0, con_out}, {144'h0, e_main[1:0]});
            chk({144'h0, ana_out}, {144'h0, e_main[7:6]});
            chk(opt_out, e_opt);
        end
        for (int i = 0; i < 8; i++) begin
            pro_in[i] = 24'($urandom);
            opt_in[i] = 24'($urandom);
        end
        for (int i = 0; i < 2; i++) begin
            con_in[i] = 24'($urandom);
            ana_in[i] = 24'($urandom);
        end
        // Settings wander every cycle; only a tick may load them
        r = {$urandom, $urandom};
        cfg_in = r[$bits(aior_cfg_s)-1:0];
        frame_tick = mix && ($urandom % 4 == 0);
        predict();
        if (frame_tick) act = cfg_in;
        valid = 1'b1;
    endtask

    // ------------------------------------------------------------------------
    // Timeout
    // ------------------------------------------------------------------------
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            end_sim();
        end
    end

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        {pro_in, opt_in, con_in, ana_in, cfg_in, frame_tick} = '0;
        {card_pin, midi_pin, ser_pin, card_wr, card_addr} = '0;
        act = CFG_RST;
        void'($urandom(32'h42176c62));
        repeat (3) @(negedge clk);
        rst = 1'b0;
        // Default routing first, then random settings with sparse ticks
        repeat (20) cyc();
        mix = 1'b1;
        repeat (400) cyc();
        mix = 1'b0;
        // No card: each serial line lights busy, which then times out
        for (int p = 0; p < 2; p++) begin
            seen = 1'b0;
            if (p == 0) midi_pin = ~midi_pin;
            else ser_pin = ~ser_pin;
            for (int k = 0; k < 8; k++) begin
                cyc();
                seen |= busy_led;
            end
            chk(seen, 1'b1);
            chk(busy_led, 1'b1);
            repeat (ACT + 8) cyc();
            chk(busy_led, 1'b0);
        end
        // Card present: activity no longer shows, writes do
        card_pin = 1'b1;
        repeat (4) cyc();
        midi_pin = ~midi_pin;
        seen = 1'b0;
        for (int k = 0; k < 8; k++) begin
            cyc();
            seen |= busy_led;
        end
        chk(seen, 1'b0);
        foreach (addrs[j]) begin
            card_wr = 1'b1;
            card_addr = addrs[j];
            cyc();
            chk(busy_led, 1'b1);
            chk(card_wr_ok, addrs[j] < CARD_BYTES);
            chk(card_range_err, addrs[j] >= CARD_BYTES);
            card_wr = 1'b0;
            cyc();
            chk({busy_led, card_wr_ok, card_range_err}, 3'h0);
        end
        end_sim();
    end
endmodule
